// ### bench/lsr_client.sv
// Purpose: Remote client model sending read frames and collecting answers.
// Assumes: A frame is sent whole, one byte per cycle.
// Notes: When slow is set the client drops tx_ready every other cycle.
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module lsr_client (
    input wire logic clk_sys,
    output logic frame_start,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data
);
    logic slow;
    logic [7:0] rsp[$];
    initial begin
        frame_start = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
        slow = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready) rsp.push_back(tx_data);
        #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = `LSR_CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `LSR_CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc16
    // Two answer registers from byte i on, most significant first, low half taken unsigned.
    function automatic int join32(input int i);
        return int'({rsp[i], rsp[i + 1], rsp[i + 2], rsp[i + 3]});
    endfunction : join32
    task automatic req(input logic [7:0] srv, input logic [7:0] fn, input logic [15:0] addr,
        input logic [15:0] n, input logic bad);
        logic [7:0] f[$];
        logic [15:0] c;
        f = '{srv, fn, addr[15:8], addr[7:0], n[15:8], n[7:0]};
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        rsp.delete();
        @(posedge clk_sys) #1 frame_start = 1'b1;
        foreach (f[i]) begin
            @(posedge clk_sys) #1 frame_start = 1'b0;
            rx_valid = 1'b1;
            rx_data = f[i];
        end
        @(posedge clk_sys) #1 rx_valid = 1'b0;
    endtask : req
endmodule : lsr_client

// ### bench/lsr_readout_asserts.sv
// Purpose: Port-level checks on the answer stream of the status readout.
// Assumes: Only the top module ports are visible.
// Notes: A byte index tracks the answer so frame fields can be told apart.
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module lsr_readout_asserts (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] server_addr,
    input wire logic rx_valid,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic busy
);
    logic [8:0] idx_r, idx_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    always_comb begin
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        if (!busy) idx_nxt = 9'h000;
        else if (tx_valid && tx_ready && ce) idx_nxt = idx_r + 9'h001;
        if (idx_r == 9'h002 && tx_valid) cnt_nxt = tx_data;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idx_r <= 9'h000;
            cnt_r <= 8'h00;
        end else begin
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    byte_hold_a: assert property (tx_valid && !(tx_ready && ce) |=> tx_valid && $stable(tx_data)
        && $stable(tx_last)) else $error("answer byte changed before taken");
    srv_first_a: assert property (idx_r == 9'h000 && tx_valid |-> tx_data == server_addr)
        else $error("first answer byte is not the server address");
    func_echo_a: assert property (idx_r == 9'h001 && tx_valid |-> tx_data == `LSR_FUNC_READ)
        else $error("function code not echoed");
    count_even_a: assert property (idx_r == 9'h002 && tx_valid |-> !tx_data[0] && tx_data != 8'h00)
        else $error("byte count not twice a register count");
    last_pos_a: assert property (tx_valid && tx_last |-> idx_r == {1'b0, cnt_r} + 9'h004)
        else $error("frame length disagrees with byte count");
    end_quiet_a: assert property (tx_valid && tx_ready && ce && tx_last |=> !tx_valid && !busy)
        else $error("answer continues after last byte");
    valid_busy_a: assert property (tx_valid |-> busy) else $error("byte offered while idle");
    answer_cause_a: assert property ($rose(busy) |-> $past(rx_valid))
        else $error("answer started without a request byte");
    cover property (tx_valid && tx_ready && tx_last);
    cover property (tx_valid && !tx_ready);
    cover property (idx_r == 9'h0E6 && tx_last);
endmodule : lsr_readout_asserts
bind lsr_readout lsr_readout_asserts u_lsr_readout_asserts (.clk_sys, .resetn, .ce, .server_addr,
    .rx_valid, .tx_ready, .tx_valid, .tx_data, .tx_last, .busy);

// ### bench/testbench.sv
// Purpose: Self-checking bench for the status readout.
// Assumes: Server address is held constant.
// Notes: Expected answers are built here from the register map.
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module testbench;
    logic clk_sys, resetn, motor_variant, contact_position_bit, trip_indication_bit, fault_trip_indication_bit;
    logic frame_start, rx_valid, tx_ready, tx_valid, tx_last, busy, ce;
    logic [15:0] phase1_current;
    logic [7:0] rx_data, tx_data;
    int errors = 0;
    int check_count = 0;
    int last_seen = 0;
    lsr_readout u_lsr_readout (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .server_addr(8'h2F),
        .motor_variant(motor_variant), .contact_position_bit(contact_position_bit),
        .trip_indication_bit(trip_indication_bit), .fault_trip_indication_bit(fault_trip_indication_bit),
        .phase1_current(phase1_current), .frame_start(frame_start), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .busy(busy));
    lsr_client u_lsr_client (.clk_sys(clk_sys), .frame_start(frame_start), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1) last_seen++;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [15:0] exp_word(input logic [15:0] a);
        case (a)
            16'h2EDF: return 16'h0007;
            16'h2EE0: return {13'h0000, fault_trip_indication_bit, trip_indication_bit & ~motor_variant,
                contact_position_bit};
            16'h2EEF: return phase1_current;
            default: return 16'h0000;
        endcase
    endfunction : exp_word
    task automatic read(input logic [15:0] addr, input logic [15:0] n);
        logic [7:0] e[$];
        logic [15:0] w;
        int k;
        last_seen = 0;
        u_lsr_client.req(8'h2F, `LSR_FUNC_READ, addr, n, 1'b0);
        e = '{8'h2F, `LSR_FUNC_READ, {n[6:0], 1'b0}};
        for (int i = 0; i < n; i++) begin
            w = exp_word(addr + 16'(i));
            e.push_back(w[15:8]);
            e.push_back(w[7:0]);
        end
        w = u_lsr_client.crc16(e);
        e.push_back(w[7:0]);
        e.push_back(w[15:8]);
        k = 0;
        while (u_lsr_client.rsp.size() < e.size() && k < 2000) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        check(16'(u_lsr_client.rsp.size()), 16'(e.size()));
        check({15'h0000, busy}, 16'h0000);
        check(16'(last_seen), 16'h0001);
        foreach (e[i]) if (i < u_lsr_client.rsp.size()) check({8'h00, u_lsr_client.rsp[i]}, {8'h00, e[i]});
    endtask : read
    task automatic t_current();
        phase1_current = 16'h022B;
        repeat (2) @(posedge clk_sys);
        #1;
        read(16'h2EEF, 16'h0001);
        $display("test current done");
    endtask : t_current
    task automatic t_status();
        for (int m = 0; m < 16; m++) begin
            {motor_variant, fault_trip_indication_bit, trip_indication_bit, contact_position_bit} = 4'(m);
            repeat (4) @(posedge clk_sys);
            #1;
            read(16'h2EDF, 16'h0002);
            check(16'(u_lsr_client.join32(3) >>> 16), 16'h0007);
        end
        $display("test status done");
    endtask : t_status
    task automatic t_table();
        u_lsr_client.slow = 1'b1;
        phase1_current = 16'hBEEF;
        read(16'h2EDF, 16'h0071);
        u_lsr_client.slow = 1'b0;
        $display("test table done");
    endtask : t_table
    task automatic t_refuse();
        for (int i = 0; i < 4; i++) begin
            u_lsr_client.req(i == 0 ? 8'h30 : 8'h2F, i == 1 ? 8'h06 : 8'h03, 16'h2EDF,
                {15'h0000, i != 3}, i == 2);
            repeat (30) @(posedge clk_sys);
            #1;
            check(16'(u_lsr_client.rsp.size()), 16'h0000);
        end
        read(16'h2EE0, 16'h0001);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_freeze();
        ce = 1'b0;
        u_lsr_client.req(8'h2F, `LSR_FUNC_READ, 16'h2EEF, 16'h0001, 1'b0);
        repeat (30) @(posedge clk_sys);
        #1;
        check(16'(u_lsr_client.rsp.size()), 16'h0000);
        check({15'h0000, busy}, 16'h0000);
        ce = 1'b1;
        read(16'h2EEF, 16'h0001);
        $display("test freeze done");
    endtask : t_freeze
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        summarize();
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        {motor_variant, fault_trip_indication_bit, trip_indication_bit, contact_position_bit} = 4'h0;
        phase1_current = 16'h0000;
        repeat (10) @(posedge clk_sys);
        #1 resetn = 1'b1;
        t_current();
        t_status();
        t_table();
        t_refuse();
        t_freeze();
        summarize();
    end
endmodule : testbench

// ### design/lsr_cfg.svh
// Purpose: Constants for the legacy status register readout.
// Assumes: Byte-wide request and response streams.
// Notes: Register addresses are wire addresses, one less than the register numbers.
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_FUNC_READ 8'h03
`define LSR_TABLE_BASE 16'h2EDF
`define LSR_TABLE_LEN 16'h0071
`define LSR_ADDR_MASK 16'h2EDF
`define LSR_ADDR_STATUS 16'h2EE0
`define LSR_ADDR_CURRENT 16'h2EEF
`define LSR_BIT_CONTACT 0
`define LSR_BIT_TRIP 1
`define LSR_BIT_FAULT 2
`define LSR_MASK_VALUE 16'h0007
`define LSR_SERVER_ADDR_RST 8'h2F
`define LSR_CRC_INIT 16'hFFFF
`define LSR_CRC_POLY 16'hA001
`endif

// ### design/lsr_crc.sv
// Purpose: Frame check code accumulator, one byte per enabled cycle.
// Assumes: Standard reflected CRC-16 with the usual start value.
// Notes: Reloaded with the start value by a start pulse so a new frame never inherits old state.
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module lsr_crc (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic start,
    input wire logic upd,
    input wire logic [7:0] data,
    output logic [15:0] crc
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            v = v[0] ? ((v >> 1) ^ `LSR_CRC_POLY) : (v >> 1);
        end
        return v;
    endfunction : crc_byte

    always_comb begin
        crc_nxt = crc_r;
        if (start) begin
            crc_nxt = `LSR_CRC_INIT;
        end else if (upd) begin
            crc_nxt = crc_byte(crc_r, data);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crc_r <= `LSR_CRC_INIT;
        end else if (ce) begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;
endmodule : lsr_crc

// ### design/lsr_pkg.sv
// Purpose: Types for the legacy status register readout.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the request parser and response states.
package lsr_pkg;
    typedef enum logic [3:0] {
        LSR_RX_SRV,
        LSR_RX_FUNC,
        LSR_RX_AHI,
        LSR_RX_ALO,
        LSR_RX_NHI,
        LSR_RX_NLO,
        LSR_RX_CLO,
        LSR_RX_CHI,
        LSR_RX_SKIP
    } lsr_rx_t;
    typedef enum logic [2:0] {
        LSR_TX_IDLE,
        LSR_TX_SRV,
        LSR_TX_FUNC,
        LSR_TX_CNT,
        LSR_TX_DHI,
        LSR_TX_DLO,
        LSR_TX_CLO,
        LSR_TX_CHI
    } lsr_tx_t;
endpackage : lsr_pkg

// ### design/lsr_readout.sv
// Purpose: Read-only status table served to a remote client over byte streams.
// Assumes: Request bytes arrive from a framing layer on clk_sys; breaker contacts come from pins.
// Notes: Only the mask, status and phase-1 current registers hold data; other table words read zero.
// Behaviour
// R1 - A 32-bit value spans two registers, the more significant one sent first.
// R2 - The client reads signed 32-bit values as two's complement with the low half unsigned.
// R3 - The wire address of a register is its register number minus one.
// R4 - A read request carries server address, function 0x03, start address and count high byte first, then check code.
// R5 - The answer carries server address, echoed function, byte count, each value high byte first, then check code.
// R6 - The byte count is twice the number of registers requested.
// R7 - The common table starts at 0x2EDF, spans 113 registers and is returned by one read.
// R8 - The register at 0x2EDF holds a mask flagging which status bits are valid.
// R9 - Status bit 0 reads 1 when the contacts are closed and 0 when open.
// R10 - Status bit 1 reads 1 after a fault, shunt or push-to-trip, and 0 otherwise.
// R11 - On motor-driven variants status bit 1 always reads 0.
// R12 - Status bit 2 reads 0 when no electrical fault trip has occurred.
// R13 - Status bit 2 reads 1 after an electrical fault trip, including test trips.
// R14 - The phase-1 current register holds the rms current as unsigned amperes.
// R15 - Table registers are readable by the read function and never writable.
// R16 - Frames with another server address or a bad check code are ignored.
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module lsr_readout (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] server_addr,
    input wire logic motor_variant,
    input wire logic contact_position_bit,
    input wire logic trip_indication_bit,
    input wire logic fault_trip_indication_bit,
    input wire logic [15:0] phase1_current,
    input wire logic frame_start,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic busy
);
    lsr_pkg::lsr_rx_t rx_r, rx_nxt;
    lsr_pkg::lsr_tx_t tx_r, tx_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0] chk_lo_r, chk_lo_nxt;
    logic [7:0] srv_r, srv_nxt;
    logic [7:0] txd_r, txd_nxt;
    logic txv_r, txv_nxt;
    logic txl_r, txl_nxt;
    logic [7:0] lo_r, lo_nxt;
    logic [2:0] pin_s1_r, pin_s2_r;
    logic [15:0] cur_r;
    logic [15:0] word;
    logic crc_start, crc_upd;
    logic [7:0] crc_data;
    logic [15:0] crc;
    logic fire;

    lsr_crc u_crc (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .start(crc_start),
        .upd(crc_upd),
        .data(crc_data),
        .crc(crc)
    );

    // Contact pins cross in from the breaker through two flops.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            cur_r <= 16'h0000;
        end else if (ce) begin
            pin_s1_r <= {fault_trip_indication_bit, trip_indication_bit, contact_position_bit};
            pin_s2_r <= pin_s1_r;
            cur_r <= phase1_current;
        end
    end

    function automatic logic [15:0] table_word(input logic [15:0] a, input logic [2:0] p,
                                               input logic motor, input logic [15:0] cur);
        logic [15:0] s;
        s = 16'h0000;
        s[`LSR_BIT_CONTACT] = p[0]; // see R9
        s[`LSR_BIT_TRIP] = p[1] & ~motor; // see R10 see R11
        s[`LSR_BIT_FAULT] = p[2]; // see R12 see R13
        unique case (a)
            `LSR_ADDR_MASK: table_word = `LSR_MASK_VALUE; // see R8
            `LSR_ADDR_STATUS: table_word = s;
            `LSR_ADDR_CURRENT: table_word = cur; // see R14
            default: table_word = 16'h0000;
        endcase
    endfunction : table_word

    assign word = table_word(addr_r, pin_s2_r, motor_variant, cur_r);
    // Stalling on tx_ready holds the byte, so the check code sees each byte once.
    assign fire = txv_r & tx_ready;

    always_comb begin
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        chk_lo_nxt = chk_lo_r;
        srv_nxt = srv_r;
        txd_nxt = txd_r;
        txv_nxt = txv_r;
        txl_nxt = txl_r;
        lo_nxt = lo_r;
        crc_start = 1'b0;
        crc_upd = 1'b0;
        crc_data = rx_data;
        if (tx_r == lsr_pkg::LSR_TX_IDLE) begin
            if (frame_start) begin
                rx_nxt = lsr_pkg::LSR_RX_SRV;
                crc_start = 1'b1;
            end else if (rx_valid) begin
                crc_upd = (rx_r != lsr_pkg::LSR_RX_CLO) && (rx_r != lsr_pkg::LSR_RX_CHI);
                unique case (rx_r)
                    lsr_pkg::LSR_RX_SRV: begin
                        srv_nxt = rx_data;
                        // Foreign server addresses are dropped. see R16
                        rx_nxt = (rx_data == server_addr) ? lsr_pkg::LSR_RX_FUNC : lsr_pkg::LSR_RX_SKIP;
                    end
                    lsr_pkg::LSR_RX_FUNC: begin
                        // Any other function, writes included, gets no answer. see R15
                        rx_nxt = (rx_data == `LSR_FUNC_READ) ? lsr_pkg::LSR_RX_AHI : lsr_pkg::LSR_RX_SKIP;
                    end
                    lsr_pkg::LSR_RX_AHI: begin
                        addr_nxt[15:8] = rx_data; // see R4
                        rx_nxt = lsr_pkg::LSR_RX_ALO;
                    end
                    lsr_pkg::LSR_RX_ALO: begin
                        addr_nxt[7:0] = rx_data; // see R3
                        rx_nxt = lsr_pkg::LSR_RX_NHI;
                    end
                    lsr_pkg::LSR_RX_NHI: begin
                        cnt_nxt[15:8] = rx_data;
                        rx_nxt = lsr_pkg::LSR_RX_NLO;
                    end
                    lsr_pkg::LSR_RX_NLO: begin
                        cnt_nxt[7:0] = rx_data;
                        rx_nxt = lsr_pkg::LSR_RX_CLO;
                    end
                    lsr_pkg::LSR_RX_CLO: begin
                        chk_lo_nxt = rx_data;
                        rx_nxt = lsr_pkg::LSR_RX_CHI;
                    end
                    lsr_pkg::LSR_RX_CHI: begin
                        rx_nxt = lsr_pkg::LSR_RX_SKIP;
                        // A bad check code or a count the 8-bit byte count cannot hold is dropped. see R16
                        if ({rx_data, chk_lo_r} == crc && cnt_r != 16'h0000 && cnt_r <= 16'h007F) begin
                            tx_nxt = lsr_pkg::LSR_TX_SRV;
                            crc_start = 1'b1;
                            txd_nxt = srv_r;
                            txv_nxt = 1'b1;
                        end
                    end
                    lsr_pkg::LSR_RX_SKIP: begin
                        rx_nxt = lsr_pkg::LSR_RX_SKIP;
                    end
                endcase
            end
        end else if (fire) begin
            crc_upd = (tx_r != lsr_pkg::LSR_TX_CLO) && (tx_r != lsr_pkg::LSR_TX_CHI);
            crc_data = txd_r;
            unique case (tx_r)
                lsr_pkg::LSR_TX_SRV: begin
                    tx_nxt = lsr_pkg::LSR_TX_FUNC;
                    txd_nxt = `LSR_FUNC_READ; // see R5
                end
                lsr_pkg::LSR_TX_FUNC: begin
                    tx_nxt = lsr_pkg::LSR_TX_CNT;
                    txd_nxt = {cnt_r[6:0], 1'b0}; // see R6
                end
                lsr_pkg::LSR_TX_CNT, lsr_pkg::LSR_TX_DLO: begin
                    if (cnt_r == 16'h0000) begin
                        // The low check byte must fold in the data byte the accumulator takes at this edge.
                        tx_nxt = lsr_pkg::LSR_TX_CLO;
                        txd_nxt = crc_byte_lo_fix(crc, txd_r);
                    end else begin
                        // Both halves are captured together so a changing value never tears.
                        tx_nxt = lsr_pkg::LSR_TX_DHI;
                        txd_nxt = word[15:8]; // see R1 see R7
                        lo_nxt = word[7:0];
                        addr_nxt = addr_r + 16'h0001;
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                lsr_pkg::LSR_TX_DHI: begin
                    tx_nxt = lsr_pkg::LSR_TX_DLO;
                    txd_nxt = lo_r;
                end
                lsr_pkg::LSR_TX_CLO: begin
                    tx_nxt = lsr_pkg::LSR_TX_CHI;
                    txd_nxt = crc[15:8];
                end
                lsr_pkg::LSR_TX_CHI: begin
                    tx_nxt = lsr_pkg::LSR_TX_IDLE;
                    txv_nxt = 1'b0;
                end
                lsr_pkg::LSR_TX_IDLE: begin
                    tx_nxt = lsr_pkg::LSR_TX_IDLE;
                end
            endcase
            txl_nxt = (tx_nxt == lsr_pkg::LSR_TX_CHI);
        end
    end

    // Low check byte includes the last data byte, which the accumulator takes in the same edge.
    function automatic logic [7:0] crc_byte_lo_fix(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            v = v[0] ? ((v >> 1) ^ `LSR_CRC_POLY) : (v >> 1);
        end
        return v[7:0];
    endfunction : crc_byte_lo_fix

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_r <= lsr_pkg::LSR_RX_SKIP;
            tx_r <= lsr_pkg::LSR_TX_IDLE;
            addr_r <= 16'h0000;
            cnt_r <= 16'h0000;
            chk_lo_r <= 8'h00;
            srv_r <= 8'h00;
            txd_r <= 8'h00;
            txv_r <= 1'b0;
            txl_r <= 1'b0;
            lo_r <= 8'h00;
            busy <= 1'b0;
        end else if (ce) begin
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            chk_lo_r <= chk_lo_nxt;
            srv_r <= srv_nxt;
            txd_r <= txd_nxt;
            txv_r <= txv_nxt;
            txl_r <= txl_nxt;
            lo_r <= lo_nxt;
            busy <= (tx_nxt != lsr_pkg::LSR_TX_IDLE);
        end
    end

    assign tx_valid = txv_r;
    assign tx_data = txd_r;
    assign tx_last = txl_r;
endmodule : lsr_readout
